//--- pma_regs.vh
// pma_regs.vh: register map, configuration fields and pin assignments of the macrocell array
// assumes: included by the array module, word-addressed avalon slave, 100 MHz sys_clk
//
// Notes on behaviour
// - five product terms ORed, cascade to forty
// - xor second input: term, one or zero
// - data from xor, product term or pin
// - d, t, jk, sr flip-flop or latch
// - clock: three global pins or term, rising
// - clock enable term blocks global clock edges
// - reset: global clear, term, both, or off
// - preset: product term or off only
// - output and feedback each registered or combinatorial
// - enable from two pins, pin or macrocell
// - bus: all pins, 64 feedbacks; 40 picked
// - inverted term folds back to block's sixteen
// - keeper holds last driven pin level
// - sleep pin high freezes logic and outputs
// - pins ignored until sleep pin low
// - sleep pins lose pin role, cell stays
// - fuse hides pattern, signature readable, erase clears
// - configuration halts logic, all pins released
// - jtag pins reserved, cells stay buried usable
`ifndef PMA_REGS_VH
`define PMA_REGS_VH

// sizes
`define PMA_CELLS 64
`define PMA_PTS 5
`define PMA_BLK_CELLS 16
`define PMA_BLK_IN 40
`define PMA_BLOCKS 4
`define PMA_CHAIN 8
`define PMA_SW_N 160
`define PMA_PTW_N 1280
`define PMA_BUS_W 134

// global bus layout
`define PMA_BUS_GCLK 64
`define PMA_BUS_GCLR 67
`define PMA_BUS_OE0 68
`define PMA_BUS_OE1 69
`define PMA_BUS_FB 70

// word addresses
`define PMA_A_CTRL 11'h000
`define PMA_A_STATUS 11'h001
`define PMA_A_SIG 11'h002
`define PMA_A_KEEP_LO 11'h003
`define PMA_A_KEEP_HI 11'h004
`define PMA_A_CELL 11'h040
`define PMA_A_CELL_END 11'h080
`define PMA_A_SW 11'h080
`define PMA_A_SW_END 11'h120
`define PMA_A_PT 11'h200
`define PMA_A_PT_END 11'h700

// control and status bits
`define PMA_C_ISC 0
`define PMA_C_PD_EN 1
`define PMA_C_JTAG_EN 2
`define PMA_C_FUSE 3
`define PMA_C_ERASE 4
`define PMA_S_FUSE 0
`define PMA_S_PD 1
`define PMA_S_ISC 2
`define PMA_S_ERASED 3

// cell configuration word fields
`define PMA_F_XSEL 1:0
`define PMA_F_DSEL 3:2
`define PMA_F_MODE 6:4
`define PMA_F_CSEL 8:7
`define PMA_F_CE 9
`define PMA_F_CLR 11:10
`define PMA_F_SET 12
`define PMA_F_OREG 13
`define PMA_F_FBREG 14
`define PMA_F_OESRC 17:15
`define PMA_F_OEIDX 23:18
`define PMA_F_CASC 24
`define PMA_F_ORM 29:25
`define PMA_F_FOLD 31:30

// storage modes
`define PMA_M_D 3'h0
`define PMA_M_T 3'h1
`define PMA_M_JK 3'h2
`define PMA_M_SR 3'h3
`define PMA_M_LATCH 3'h4

// reserved pins
`define PMA_PD1_PIN 11
`define PMA_PD2_PIN 50
`define PMA_PD_MASK 64'h0004_0000_0000_0800
`define PMA_JTAG_MASK 64'h1000_2000_0001_4000

`endif

//--- pma_macrocell_array.v
// pma_macrocell_array.v: 64-cell programmable logic fabric with avalon configuration port
// assumes: pins and global inputs are asynchronous; one sys_clk domain models the fabric
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`include "pma_regs.vh"
`default_nettype none

module pma_macrocell_array (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // avalon-mm slave
  input wire [10:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  // dedicated pins
  input wire [2:0] global_clock_pins,
  input wire global_clear,
  input wire [1:0] oe_pins,
  // user i/o pins
  input wire [63:0] io_in,
  input wire [63:0] io_ext_drv,
  output wire [63:0] io_out,
  output wire [63:0] io_oe
);

  // ==========================================================
  // functions
  function pt_eval;
    input [55:0] v;
    input [55:0] t;
    input [55:0] c;
    begin
      pt_eval = &((v | ~t) & (~v | ~c));
    end
  endfunction

  function bus_pick;
    input [133:0] v;
    input [7:0] s;
    begin
      bus_pick = (s < `PMA_BUS_W) ? v[s] : 1'b0;
    end
  endfunction

  // ==========================================================
  // state
  reg [31:0] ptw [0:`PMA_PTW_N-1];
  reg [31:0] cell_cfg [0:`PMA_CELLS-1];
  reg [7:0] sw_sel [0:`PMA_SW_N-1];
  reg [63:0] keep_en_reg;
  reg [15:0] sig_reg;
  reg isc_reg;
  reg pd_en_reg;
  reg jtag_en_reg;
  reg fuse_reg;
  reg erased_reg;
  reg ack_reg;
  reg [31:0] rdata_reg;
  reg [133:0] sync1_reg;
  reg [133:0] sync2_reg;
  reg [133:0] bus_reg;
  reg [63:0] fold_reg;
  reg [63:0] q_reg;
  reg [63:0] clk_prev_reg;
  reg [63:0] keep_reg;
  reg [63:0] io_out_reg;
  reg [63:0] io_oe_reg;

  // comb
  reg [159:0] blk_in;
  reg [319:0] pt_all;
  reg [63:0] sum;
  reg [63:0] q_next;
  reg [63:0] clk_lvl;
  reg [63:0] fb_val;
  reg [63:0] out_val;
  reg [63:0] oe_val;
  reg [63:0] fold_next;
  reg [31:0] cfg;
  reg [55:0] vin;
  reg [4:0] ptc;
  reg s_or;
  reg xb;
  reg xo;
  reg d;
  reg nv;
  reg rise;
  reg clr;
  reg [31:0] rd_val;
  integer i;
  integer p;
  integer b;
  integer s;
  integer k;
  integer j;

  wire [63:0] io_in_s = sync2_reg[63:0];
  wire [63:0] drv_s = sync2_reg[127:64];
  wire [10:0] off_cell = avs_address - `PMA_A_CELL;
  wire [10:0] off_sw = avs_address - `PMA_A_SW;
  wire [10:0] off_pt = avs_address - `PMA_A_PT;
  wire in_cell = (avs_address >= `PMA_A_CELL) && (avs_address < `PMA_A_CELL_END);
  wire in_sw = (avs_address >= `PMA_A_SW) && (avs_address < `PMA_A_SW_END);
  wire in_pt = (avs_address >= `PMA_A_PT) && (avs_address < `PMA_A_PT_END);
  wire wr_go = avs_write & ack_reg;
  wire erase_now = wr_go && (avs_address == `PMA_A_CTRL) && avs_writedata[`PMA_C_ERASE] &&
    isc_reg;
  wire cfg_wr = wr_go & isc_reg;
  // sleep request from either pin, only with the option on
  wire pd_now = pd_en_reg & (io_in_s[`PMA_PD1_PIN] | io_in_s[`PMA_PD2_PIN]);
  // pins taken by sleep control or the jtag port
  wire [63:0] ded_mask = (jtag_en_reg ? `PMA_JTAG_MASK : 64'h0) |
    (pd_en_reg ? `PMA_PD_MASK : 64'h0);
  wire [63:0] driven = io_oe_reg | drv_s;
  wire [63:0] pin_src = (io_oe_reg & io_out_reg) | (~io_oe_reg & io_in_s);
  wire [63:0] pin_lvl = (driven & pin_src) | (~driven & keep_en_reg & keep_reg);

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata = rdata_reg;
  assign io_out = io_out_reg;
  assign io_oe = io_oe_reg;

  // ==========================================================
  // pin synchronisers
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_reg <= {`PMA_BUS_W{1'b0}};
      sync2_reg <= {`PMA_BUS_W{1'b0}};
    end else begin
      sync1_reg <= {oe_pins, global_clear, global_clock_pins, io_ext_drv, io_in};
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================
  // macrocell logic
  always @* begin
    blk_in = 160'h0;
    for (b = 0; b < `PMA_BLOCKS; b = b + 1) begin
      for (s = 0; s < `PMA_BLK_IN; s = s + 1) begin
        blk_in[b*`PMA_BLK_IN+s] = bus_pick(bus_reg, sw_sel[b*`PMA_BLK_IN+s]);
      end
    end
    pt_all = 320'h0;
    sum = 64'h0;
    q_next = q_reg;
    clk_lvl = 64'h0;
    fb_val = 64'h0;
    out_val = 64'h0;
    oe_val = 64'h0;
    fold_next = 64'h0;
    cfg = 32'h0;
    vin = 56'h0;
    ptc = 5'h0;
    s_or = 1'b0;
    xb = 1'b0;
    xo = 1'b0;
    d = 1'b0;
    nv = 1'b0;
    rise = 1'b0;
    clr = 1'b0;
    for (i = 0; i < `PMA_CELLS; i = i + 1) begin
      b = i / `PMA_BLK_CELLS;
      cfg = cell_cfg[i];
      vin = {fold_reg[b*`PMA_BLK_CELLS+:16], blk_in[b*`PMA_BLK_IN+:40]};
      for (p = 0; p < `PMA_PTS; p = p + 1) begin
        k = (i * `PMA_PTS + p) * 4;
        pt_all[i*`PMA_PTS+p] = pt_eval(vin, {ptw[k+1][23:0], ptw[k]},
          {ptw[k+3][23:0], ptw[k+2]});
      end
      ptc = pt_all[i*`PMA_PTS+:5];
      s_or = |(ptc & cfg[`PMA_F_ORM]);
      if (cfg[`PMA_F_CASC] && ((i % `PMA_CHAIN) != 0)) begin
        s_or = s_or | sum[i-1];
      end
      sum[i] = s_or;
      case (cfg[`PMA_F_XSEL])
        2'h0: xb = 1'b0;
        2'h1: xb = 1'b1;
        default: xb = ptc[0];
      endcase
      xo = s_or ^ xb;
      case (cfg[`PMA_F_DSEL])
        2'h0: d = xo;
        2'h1: d = ptc[1];
        default: d = bus_reg[i];
      endcase
      if (cfg[`PMA_F_CSEL] == 2'h3) begin
        clk_lvl[i] = ptc[2];
      end else begin
        clk_lvl[i] = bus_reg[`PMA_BUS_GCLK+cfg[`PMA_F_CSEL]];
      end
      rise = clk_lvl[i] & ~clk_prev_reg[i] &
        (~cfg[`PMA_F_CE] | (cfg[`PMA_F_CSEL] == 2'h3) | ptc[3]);
      case (cfg[`PMA_F_MODE])
        `PMA_M_T: nv = q_reg[i] ^ d;
        `PMA_M_JK: nv = (d & ~q_reg[i]) | (~ptc[1] & q_reg[i]);
        `PMA_M_SR: nv = d | (~ptc[1] & q_reg[i]);
        default: nv = d;
      endcase
      if (cfg[`PMA_F_MODE] == `PMA_M_LATCH) begin
        if (clk_lvl[i]) begin
          q_next[i] = d;
        end
      end else if (rise) begin
        q_next[i] = nv;
      end
      case (cfg[`PMA_F_CLR])
        2'h0: clr = 1'b0;
        2'h1: clr = bus_reg[`PMA_BUS_GCLR];
        2'h2: clr = ptc[4];
        default: clr = bus_reg[`PMA_BUS_GCLR] | ptc[4];
      endcase
      if (clr) begin
        q_next[i] = 1'b0;
      end else if (cfg[`PMA_F_SET] && ptc[3]) begin
        q_next[i] = 1'b1;
      end
      out_val[i] = cfg[`PMA_F_OREG] ? q_reg[i] : xo;
      fb_val[i] = cfg[`PMA_F_FBREG] ? q_reg[i] : xo;
      fold_next[i] = ~ptc[cfg[`PMA_F_FOLD]];
      case (cfg[`PMA_F_OESRC])
        3'h0: oe_val[i] = 1'b0;
        3'h1: oe_val[i] = 1'b1;
        3'h2: oe_val[i] = bus_reg[`PMA_BUS_OE0];
        3'h3: oe_val[i] = ~bus_reg[`PMA_BUS_OE0];
        3'h4: oe_val[i] = bus_reg[`PMA_BUS_OE1];
        3'h5: oe_val[i] = ~bus_reg[`PMA_BUS_OE1];
        3'h6: oe_val[i] = bus_reg[cfg[`PMA_F_OEIDX]];
        default: oe_val[i] = bus_reg[`PMA_BUS_FB+cfg[`PMA_F_OEIDX]];
      endcase
    end
  end

  // ==========================================================
  // fabric state, halted by configuration or sleep
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_reg <= {`PMA_BUS_W{1'b0}};
      fold_reg <= 64'h0;
      q_reg <= 64'h0;
      clk_prev_reg <= 64'h0;
      keep_reg <= 64'h0;
      io_out_reg <= 64'h0;
      io_oe_reg <= 64'h0;
    end else if (isc_reg) begin
      io_oe_reg <= 64'h0;
    end else if (!pd_now) begin
      bus_reg <= {fb_val, sync2_reg[133:128], pin_lvl & ~ded_mask};
      fold_reg <= fold_next;
      q_reg <= q_next;
      clk_prev_reg <= clk_lvl;
      keep_reg <= pin_lvl;
      io_out_reg <= out_val;
      io_oe_reg <= oe_val & ~ded_mask;
    end
  end

  // ==========================================================
  // register read mux
  always @* begin
    rd_val = 32'h0;
    if (avs_address == `PMA_A_CTRL) begin
      rd_val = {29'h0, jtag_en_reg, pd_en_reg, isc_reg};
    end else if (avs_address == `PMA_A_STATUS) begin
      rd_val = {28'h0, erased_reg, isc_reg, pd_now, fuse_reg};
    end else if (avs_address == `PMA_A_SIG) begin
      rd_val = {16'h0, sig_reg};
    end else if (!fuse_reg) begin
      if (avs_address == `PMA_A_KEEP_LO) begin
        rd_val = keep_en_reg[31:0];
      end else if (avs_address == `PMA_A_KEEP_HI) begin
        rd_val = keep_en_reg[63:32];
      end else if (in_cell) begin
        rd_val = cell_cfg[off_cell[5:0]];
      end else if (in_sw) begin
        rd_val = {24'h0, sw_sel[off_sw[7:0]]};
      end else if (in_pt) begin
        rd_val = ptw[off_pt];
      end
    end
  end

  // ==========================================================
  // avalon slave, one wait cycle per access
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
      if (avs_read && !ack_reg) begin
        rdata_reg <= rd_val;
      end
    end
  end

  // control and pattern storage
  always @(posedge sys_clk) begin
    if (sys_rst || erase_now) begin
      for (j = 0; j < `PMA_PTW_N; j = j + 1) begin
        ptw[j] <= 32'h0;
      end
      for (j = 0; j < `PMA_CELLS; j = j + 1) begin
        cell_cfg[j] <= 32'h0;
      end
      for (j = 0; j < `PMA_SW_N; j = j + 1) begin
        sw_sel[j] <= 8'h0;
      end
      keep_en_reg <= 64'h0;
      sig_reg <= 16'h0;
      fuse_reg <= 1'b0;
    end else if (cfg_wr) begin
      if (avs_address == `PMA_A_CTRL && avs_writedata[`PMA_C_FUSE]) begin
        fuse_reg <= 1'b1;
      end
      if (avs_address == `PMA_A_SIG) begin
        sig_reg <= avs_writedata[15:0];
      end
      if (avs_address == `PMA_A_KEEP_LO) begin
        keep_en_reg[31:0] <= avs_writedata;
      end
      if (avs_address == `PMA_A_KEEP_HI) begin
        keep_en_reg[63:32] <= avs_writedata;
      end
      if (in_cell) begin
        cell_cfg[off_cell[5:0]] <= avs_writedata;
      end
      if (in_sw) begin
        sw_sel[off_sw[7:0]] <= avs_writedata[7:0];
      end
      if (in_pt) begin
        ptw[off_pt] <= avs_writedata;
      end
    end
  end

  // mode bits
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      isc_reg <= 1'b0;
      pd_en_reg <= 1'b0;
      jtag_en_reg <= 1'b0;
      erased_reg <= 1'b0;
    end else begin
      if (wr_go && avs_address == `PMA_A_CTRL) begin
        isc_reg <= avs_writedata[`PMA_C_ISC];
        pd_en_reg <= avs_writedata[`PMA_C_PD_EN];
        jtag_en_reg <= avs_writedata[`PMA_C_JTAG_EN];
      end
      if (erase_now) begin
        erased_reg <= 1'b1;
      end else if (!isc_reg) begin
        erased_reg <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

//--- pma_board.sv
// pma_board.sv: board logic on the user pins of the macrocell array
// assumes: the device wins a pin where it drives; bench sets board levels
`default_nettype none
// ====
// board pin model
module pma_board (
  // clock
  input wire logic sys_clk,
  // device side
  input wire logic [63:0] io_out,
  input wire logic [63:0] io_oe,
  // bench control
  input wire logic [63:0] drv_val,
  input wire logic [63:0] drv_en,
  // pin levels
  output logic [63:0] io_in,
  output logic [63:0] io_ext_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] last_reg = 64'h0;
  // an undriven pin toggles each cycle, so only a keeper can hold it
  always_comb begin
    io_in = (io_oe & io_out) | (~io_oe & drv_en & drv_val) |
      (~io_oe & ~drv_en & ~last_reg);
    io_ext_drv = ~io_oe & drv_en;
  end
  always_ff @(posedge sys_clk) begin
    last_reg <= io_in;
  end
endmodule
`default_nettype wire

//--- pma_checker.sv
// pma_checker.sv: port assertions for the macrocell array
// assumes: bound to pma_macrocell_array, one sys_clk domain
`include "pma_regs.vh"
`default_nettype none
module pma_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // bus
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins
  input wire logic [2:0] global_clock_pins,
  input wire logic global_clear,
  input wire logic [1:0] oe_pins,
  input wire logic [63:0] io_in,
  input wire logic [63:0] io_ext_drv,
  input wire logic [63:0] io_out,
  input wire logic [63:0] io_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // control shadow: isc, sleep option, jtag, fuse
  logic [3:0] ctl_reg;
  wire logic req = avs_read || avs_write;
  wire logic ctrl_wr = avs_write && !avs_waitrequest && avs_address == `PMA_A_CTRL;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctl_reg <= 4'h0;
    end else if (ctrl_wr) begin
      ctl_reg[2:0] <= avs_writedata[2:0];
      if (ctl_reg[0] && avs_writedata[4]) begin
        ctl_reg[3] <= 1'h0;
      end else if (ctl_reg[0] && avs_writedata[3]) begin
        ctl_reg[3] <= 1'h1;
      end
    end
  end
  // ====
  // assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  first_wait_a: assert property ($rose(req) |-> avs_waitrequest)
    else $error("no wait state on new request");
  wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait");
  reset_quiet_a: assert property ($past(sys_rst) |-> io_out == 64'h0 && io_oe == 64'h0
    && avs_readdata == 32'h0) else $error("outputs not clear after reset");
  read_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (avs_read && avs_waitrequest && avs_address >= 11'h700
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  isc_hiz_a: assert property (ctl_reg[0] |=> io_oe == 64'h0)
    else $error("pin driven during configuration");
  sleep_hold_a: assert property ((ctl_reg[1] && io_in[`PMA_PD1_PIN])[*6]
    |=> $stable(io_out) && $stable(io_oe)) else $error("outputs moved while asleep");
  fuse_hide_a: assert property (ctl_reg[3] && avs_read && avs_waitrequest
    && avs_address >= 11'h003 |=> avs_readdata == 32'h0) else $error("pattern read with fuse");
  sleep_pins_a: assert property (ctl_reg[1] |=> (io_oe & `PMA_PD_MASK) == 64'h0)
    else $error("sleep pin driven");
  jtag_pins_a: assert property (ctl_reg[2] |=> (io_oe & `PMA_JTAG_MASK) == 64'h0)
    else $error("jtag pin driven");
  cover property (ctrl_wr);
  cover property (ctl_reg[1] && io_in[`PMA_PD1_PIN]);
  cover property (ctl_reg[3] && avs_read);
endmodule
bind pma_macrocell_array pma_checker chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .global_clock_pins(global_clock_pins),
  .global_clear(global_clear), .oe_pins(oe_pins), .io_in(io_in), .io_ext_drv(io_ext_drv),
  .io_out(io_out), .io_oe(io_oe));
`default_nettype wire

//--- tb.sv
// tb.sv: self-checking bench for the macrocell array
// assumes: pma_board on the pins, registers reached over avalon
`include "pma_regs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [10:0] avs_address = 11'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest;
  logic [2:0] global_clock_pins = 3'h0;
  logic global_clear = 1'h0;
  logic [1:0] oe_pins = 2'h0;
  logic [63:0] drv_val = 64'h0;
  logic [63:0] drv_en = ~64'h0;
  wire logic [63:0] io_in, io_ext_drv, io_out, io_oe;
  logic [31:0] q;
  int n_errors = 0;
  int comparisons = 0;
  always #5 sys_clk = ~sys_clk;
  pma_macrocell_array DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .global_clock_pins(global_clock_pins), .global_clear(global_clear), .oe_pins(oe_pins),
    .io_in(io_in), .io_ext_drv(io_ext_drv), .io_out(io_out), .io_oe(io_oe));
  pma_board board (.sys_clk(sys_clk), .io_out(io_out), .io_oe(io_oe), .drv_val(drv_val),
    .drv_en(drv_en), .io_in(io_in), .io_ext_drv(io_ext_drv));
  // ====
  // tasks
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", name, e, g);
      n_errors++;
    end
  endtask
  task automatic pc(input string name, input logic e, input logic g);
    chk(name, {63'h0, e}, {63'h0, g});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic bus(input logic rd, input logic [10:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge sys_clk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      i++;
    end while (avs_waitrequest !== 1'h0 && i < 20);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (avs_waitrequest !== 1'h0) begin
      n_errors++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    bus(1'h0, a, d);
  endtask
  task automatic rc(input logic [10:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'h1, a, 32'h0);
    chk($sformatf("reg %h", a), {32'h0, e}, {32'h0, q & m});
  endtask
  task automatic gclk();
    global_clock_pins[0] <= 1'h1;
    tick(4);
    global_clock_pins[0] <= 1'h0;
    tick(6);
  endtask
  // ====
  // sequence
  initial begin
    tick(3);
    sys_rst <= 1'h0;
    rc(`PMA_A_CTRL, ~32'h0, 32'h0);
    wr(`PMA_A_SIG, 32'ha5c3);
    rc(`PMA_A_SIG, 32'hffff, 32'h0);
    wr(`PMA_A_CTRL, 32'h1);
    wr(`PMA_A_CTRL, 32'h11);
    rc(`PMA_A_STATUS, 32'hc, 32'hc);
    wr(`PMA_A_SIG, 32'ha5c3);
    wr(`PMA_A_SW, 32'h1);
    wr(`PMA_A_PT, 32'h1);
    wr(`PMA_A_PT + 11'h28, 32'h1);
    wr(`PMA_A_PT + 11'h98, 32'h1);
    wr(`PMA_A_PT + 11'hac, 32'h1);
    wr(`PMA_A_PT + 11'hc9, 32'h100);
    wr(`PMA_A_CELL, 32'h0200_8000);
    wr(`PMA_A_CELL + 11'h2, 32'h0200_a001);
    wr(`PMA_A_CELL + 11'h3, 32'h0100_0000);
    wr(`PMA_A_CELL + 11'h4, 32'h0000_2014);
    wr(`PMA_A_CELL + 11'h5, 32'h0000_2048);
    wr(`PMA_A_CELL + 11'h6, 32'h0000_2404);
    wr(`PMA_A_CELL + 11'h7, 32'h0000_3000);
    wr(`PMA_A_CELL + 11'h8, 32'h0000_2204);
    wr(`PMA_A_CELL + 11'ha, 32'h0200_0000);
    wr(`PMA_A_CELL + 11'hc, 32'h0001_8000);
    wr(`PMA_A_CELL + 11'he, 32'h0000_8000);
    wr(`PMA_A_CELL + 11'h32, 32'h0000_8000);
    wr(`PMA_A_KEEP_LO, 32'h2);
    rc(`PMA_A_CELL, ~32'h0, 32'h0200_8000);
    wr(`PMA_A_CTRL, 32'h0);
    drv_val[11] <= 1'h1;
    for (int v = 1; v >= 0; v--) begin
      drv_val[1] <= v[0];
      tick(10);
      pc("out0", v[0], io_out[0]);
      pc("cascade3", v[0], io_out[3]);
      pc("fold10", !v[0], io_out[10]);
    end
    pc("oe0", 1'h1, io_oe[0]);
    pc("oe12", 1'h1, io_oe[12]);
    pc("oe50", 1'h1, io_oe[50]);
    pc("oe14", 1'h1, io_oe[14]);
    pc("preset7", 1'h1, io_out[7]);
    drv_val[11] <= 1'h0;
    drv_val[5] <= 1'h1;
    oe_pins[0] <= 1'h1;
    gclk();
    pc("reg2", 1'h1, io_out[2]);
    pc("toggle4", 1'h1, io_out[4]);
    pc("latch5", 1'h1, io_out[5]);
    pc("clr6", 1'h1, io_out[6]);
    pc("reg7", 1'h0, io_out[7]);
    pc("ce8", 1'h0, io_out[8]);
    pc("oe12 pin", 1'h0, io_oe[12]);
    drv_val[1] <= 1'h1;
    drv_val[5] <= 1'h0;
    global_clear <= 1'h1;
    tick(4);
    global_clear <= 1'h0;
    tick(6);
    pc("reg2 hold", 1'h1, io_out[2]);
    pc("toggle4 hold", 1'h1, io_out[4]);
    pc("latch5 hold", 1'h1, io_out[5]);
    pc("clr6 cleared", 1'h0, io_out[6]);
    pc("preset7 set", 1'h1, io_out[7]);
    gclk();
    pc("reg2 next", 1'h0, io_out[2]);
    pc("toggle4 next", 1'h0, io_out[4]);
    pc("latch5 next", 1'h0, io_out[5]);
    pc("clr6 next", 1'h1, io_out[6]);
    pc("preset7 next", 1'h1, io_out[7]);
    pc("ce8 next", 1'h1, io_out[8]);
    drv_en[1] <= 1'h0;
    tick(10);
    pc("keeper", 1'h1, io_out[0]);
    drv_en[1] <= 1'h1;
    wr(`PMA_A_CTRL, 32'h6);
    drv_val[11] <= 1'h1;
    tick(10);
    drv_val[1] <= 1'h0;
    tick(10);
    pc("frozen", 1'h1, io_out[0]);
    pc("sleep oe", 1'h0, io_oe[11]);
    pc("sleep oe50", 1'h0, io_oe[50]);
    pc("jtag oe14", 1'h0, io_oe[14]);
    drv_val[11] <= 1'h0;
    tick(10);
    pc("woken", 1'h0, io_out[0]);
    wr(`PMA_A_CTRL, 32'h1);
    tick(2);
    chk("oe in config", 64'h0, io_oe);
    wr(`PMA_A_CTRL, 32'h9);
    rc(`PMA_A_SIG, 32'hffff, 32'ha5c3);
    rc(`PMA_A_CELL, ~32'h0, 32'h0);
    rc(`PMA_A_STATUS, 32'h1, 32'h1);
    wr(`PMA_A_CTRL, 32'h11);
    rc(`PMA_A_STATUS, 32'h1, 32'h0);
    rc(11'h7ff, ~32'h0, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
